// ### src/sem_pkg.sv
// Shared constants of the singles event multiplexer.
package sem_pkg;
   localparam int N_CH = 16;
   localparam int MAX_FWD = 4;
   localparam int DW = 16;
   localparam int N_BRD = 8;
   localparam int CTL_W = 4;
   localparam int PROG_W = 4;
   localparam int USER_W = 8;
   localparam int PEER_W = 16;
   localparam int CNT_W = 5;
   localparam int PTR_W = 4;
   localparam int TAKEN_W = 3;
   localparam int SLOT_IDX_W = 2;
   // Positions in the synchroniser vector.
   localparam int SY_LCLK = 0;
   localparam int SY_SLICE = 1;
   localparam int SY_RDY = 2;
   localparam int SY_COINC = 3;
   localparam int SY_PEER_LSB = 4;
   localparam int SYNC_W = SY_PEER_LSB + PEER_W;
   // Diagnostic word layout: tag, peer frame count, own frame count.
   localparam logic [3:0] DIAG_TAG = 4'hD;
   localparam int DIAG_TAG_LSB = 12;
   localparam int DIAG_PEER_LSB = 5;
   localparam int DIAG_OWN_LSB = 0;
endpackage : sem_pkg

// ### src/sem_buf2.sv
// Two-entry valid/ready buffer in the event path.
`timescale 1ns/100ps
module sem_buf2 #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Fill side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   typedef struct packed {
      logic [1:0] cnt;
      logic [W-1:0] d0;
      logic [W-1:0] d1;
   } sem_buf_state_t;

   sem_buf_state_t q;
   sem_buf_state_t n;
   logic push;
   logic pop;

   assign in_ready = (q.cnt != 2'h2);
   assign out_valid = (q.cnt != 2'h0);
   assign out_data = q.d0;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      n = q;
      unique case ({push, pop})
         2'b10:
         begin
            if (q.cnt == 2'h0)
               n.d0 = in_data;
            else
               n.d1 = in_data;
            n.cnt = q.cnt + 2'h1;
         end
         2'b01:
         begin
            n.d0 = q.d1;
            n.cnt = q.cnt - 2'h1;
         end
         2'b11:
         begin
            // With two entries a push cannot occur, so cnt is one here.
            n.d0 = in_data;
         end
         2'b00:
         begin
            n = q;
         end
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         q <= '0;
      else
         q <= n;
   end
endmodule : sem_buf2

// ### src/sem_mux.sv
// Front-end singles event multiplexer with command fan-out and diagnostics.
`timescale 1ns/100ps
module sem_mux #(
   parameter int N_CH = sem_pkg::N_CH,
   parameter int DW = sem_pkg::DW,
   parameter int MAX_FWD = sem_pkg::MAX_FWD,
   parameter int N_BRD = sem_pkg::N_BRD
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Events from detector boards
   input wire logic [N_CH-1:0] ev_valid,
   input wire logic [N_CH*DW-1:0] ev_data,
   // Board control fan-out and reply fan-in
   output logic [N_BRD*sem_pkg::CTL_W-1:0] ctl_to_board,
   output logic [N_BRD*sem_pkg::PROG_W-1:0] prog_to_board,
   input wire logic [N_BRD-1:0] reply_from_board,
   input wire logic [N_BRD-1:0] reply_mask,
   // Link to the main controller
   input wire logic link_clk_in,
   input wire logic slice_in,
   input wire logic [sem_pkg::CTL_W-1:0] ctl_from_main,
   input wire logic [sem_pkg::PROG_W-1:0] prog_from_main,
   input wire logic link_ready,
   output logic link_valid,
   output logic [DW-1:0] link_data,
   output logic link_clk_out,
   output logic slice_out,
   output logic [sem_pkg::USER_W-1:0] user_to_main,
   output logic reply_to_main,
   // Peer multiplexer link
   input wire logic [sem_pkg::PEER_W-1:0] peer_in,
   output logic [sem_pkg::PEER_W-1:0] peer_out,
   // Diagnostics and clock source
   input wire logic diag_en,
   input wire logic coinc_present,
   output logic clk_src_sel
);
   typedef struct packed {
      logic [sem_pkg::SYNC_W-1:0] s1;
      logic [sem_pkg::SYNC_W-1:0] s2;
      logic lclk_d;
      logic slice_d;
      logic [sem_pkg::PTR_W-1:0] start_ptr;
      logic [sem_pkg::CNT_W-1:0] frame_acc;
      logic [sem_pkg::TAKEN_W-1:0] taken;
      logic [MAX_FWD-1:0][DW-1:0] slot;
      logic [sem_pkg::SLOT_IDX_W-1:0] wr;
      logic [sem_pkg::SLOT_IDX_W-1:0] rd;
      logic [sem_pkg::TAKEN_W-1:0] used;
      logic diag_pend;
      logic [DW-1:0] diag_word;
      logic link_valid;
      logic [DW-1:0] link_data;
      logic link_clk_out;
      logic slice_out;
      logic [sem_pkg::USER_W-1:0] user;
      logic reply;
      logic [sem_pkg::PEER_W-1:0] peer_out;
      logic clk_src_sel;
      logic [N_BRD*sem_pkg::CTL_W-1:0] ctl;
      logic [N_BRD*sem_pkg::PROG_W-1:0] prog;
   } sem_state_t;

   sem_state_t q;
   sem_state_t n;
   logic [sem_pkg::SYNC_W-1:0] sync_in;
   logic lclk_rise;
   logic slice_rise;
   logic [sem_pkg::PTR_W:0] pick;
   logic accept;
   logic buf_in_valid;
   logic [DW-1:0] buf_in_data;
   logic buf_in_ready;
   logic buf_out_valid;
   logic [DW-1:0] buf_out_data;
   logic buf_out_ready;
   logic [N_BRD*sem_pkg::CTL_W-1:0] ctl_fan;
   logic [N_BRD*sem_pkg::PROG_W-1:0] prog_fan;
   logic [sem_pkg::CNT_W:0] arrivals;

   // Returns {found, index} of the first set bit at or after start, wrapping.
   function automatic logic [sem_pkg::PTR_W:0] first_from(input logic [N_CH-1:0] vec,
                                                          input logic [sem_pkg::PTR_W-1:0] start);
      logic [sem_pkg::PTR_W:0] r;
      int k;
      r = '0;
      for (int i = 0; i < N_CH; i++)
      begin
         k = (int'(start) + i) % N_CH;
         if (!r[sem_pkg::PTR_W] && vec[k])
            r = {1'b1, sem_pkg::PTR_W'(k)};
      end
      return r;
   endfunction : first_from

   function automatic logic [sem_pkg::CNT_W-1:0] ones(input logic [N_CH-1:0] vec);
      logic [sem_pkg::CNT_W-1:0] c;
      c = '0;
      for (int i = 0; i < N_CH; i++)
         c = c + sem_pkg::CNT_W'(vec[i]);
      return c;
   endfunction : ones

   assign sync_in = {peer_in, coinc_present, link_ready, slice_in, link_clk_in};
   assign lclk_rise = q.s2[sem_pkg::SY_LCLK] && !q.lclk_d;
   assign slice_rise = q.s2[sem_pkg::SY_SLICE] && !q.slice_d;
   assign pick = first_from(ev_valid, q.start_ptr);
   // One event per cycle from the rotating start; simultaneous others are the surplus.
   assign accept = pick[sem_pkg::PTR_W] && !slice_rise && (q.taken < sem_pkg::TAKEN_W'(MAX_FWD))
                   && (q.used < sem_pkg::TAKEN_W'(MAX_FWD));
   // Diagnostic words take priority so the rate reaches the stream promptly.
   assign buf_in_valid = q.diag_pend || (q.used != '0);
   assign buf_in_data = q.diag_pend ? q.diag_word : q.slot[q.rd];
   // The link moves one word per rising link clock edge and only while main is ready.
   assign buf_out_ready = lclk_rise && q.s2[sem_pkg::SY_RDY];
   // One bit wider, so that a full frame count plus a full burst cannot wrap below the ceiling.
   assign arrivals = {1'b0, q.frame_acc} + {1'b0, ones(ev_valid)};

   generate
      for (genvar b = 0; b < N_BRD; b++)
      begin : g_board
         assign ctl_fan[b*sem_pkg::CTL_W +: sem_pkg::CTL_W] = ctl_from_main;
         assign prog_fan[b*sem_pkg::PROG_W +: sem_pkg::PROG_W] = prog_from_main;
      end
   endgenerate

   sem_buf2 #(
      .W(DW)
   ) u_buf (
      .mclk(mclk),
      .rst(rst),
      .in_valid(buf_in_valid),
      .in_data(buf_in_data),
      .in_ready(buf_in_ready),
      .out_valid(buf_out_valid),
      .out_data(buf_out_data),
      .out_ready(buf_out_ready)
   );

   always_comb
   begin
      n = q;
      n.s1 = sync_in;
      n.s2 = q.s1;
      n.lclk_d = q.s2[sem_pkg::SY_LCLK];
      n.slice_d = q.s2[sem_pkg::SY_SLICE];
      n.link_clk_out = q.s2[sem_pkg::SY_LCLK];
      n.slice_out = slice_rise;
      n.clk_src_sel = q.s2[sem_pkg::SY_COINC];
      n.ctl = ctl_fan;
      n.prog = prog_fan;
      n.reply = |(reply_from_board & reply_mask);
      n.user = {q.start_ptr, 1'b0, q.taken};
      if (slice_rise)
      begin
         n.frame_acc = '0;
         n.taken = '0;
         n.start_ptr = q.start_ptr + sem_pkg::PTR_W'(1);
         n.peer_out = sem_pkg::PEER_W'(q.frame_acc);
         if (diag_en)
         begin
            n.diag_pend = 1'b1;
            n.diag_word = '0;
            n.diag_word[sem_pkg::DIAG_TAG_LSB +: $bits(sem_pkg::DIAG_TAG)] = sem_pkg::DIAG_TAG;
            n.diag_word[sem_pkg::DIAG_PEER_LSB +: sem_pkg::CNT_W] =
               q.s2[sem_pkg::SY_PEER_LSB +: sem_pkg::CNT_W];
            n.diag_word[sem_pkg::DIAG_OWN_LSB +: sem_pkg::CNT_W] = q.frame_acc;
         end
      end
      else
      begin
         // Counts arrivals, saturating at the channel count N_CH.
         if (arrivals > (sem_pkg::CNT_W + 1)'(N_CH))
            n.frame_acc = sem_pkg::CNT_W'(N_CH);
         else
            n.frame_acc = arrivals[sem_pkg::CNT_W-1:0];
         if (accept)
            n.taken = q.taken + sem_pkg::TAKEN_W'(1);
      end
      if (accept)
      begin
         n.slot[q.wr] = ev_data[pick[sem_pkg::PTR_W-1:0]*DW +: DW];
         n.wr = q.wr + sem_pkg::SLOT_IDX_W'(1);
      end
      if (buf_in_valid && buf_in_ready)
      begin
         // A word queued by a new frame in this very cycle must survive the push of the old one.
         if (q.diag_pend && !(slice_rise && diag_en))
            n.diag_pend = 1'b0;
         else if (!q.diag_pend)
            n.rd = q.rd + sem_pkg::SLOT_IDX_W'(1);
      end
      n.used = q.used + sem_pkg::TAKEN_W'(accept)
               - sem_pkg::TAKEN_W'(buf_in_valid && buf_in_ready && !q.diag_pend);
      if (lclk_rise)
      begin
         n.link_valid = buf_out_valid && buf_out_ready;
         if (buf_out_valid && buf_out_ready)
            n.link_data = buf_out_data;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         q <= '0;
      else
         q <= n;
   end

   assign link_valid = q.link_valid;
   assign link_data = q.link_data;
   assign link_clk_out = q.link_clk_out;
   assign slice_out = q.slice_out;
   assign user_to_main = q.user;
   assign reply_to_main = q.reply;
   assign peer_out = q.peer_out;
   assign clk_src_sel = q.clk_src_sel;
   assign ctl_to_board = q.ctl;
   assign prog_to_board = q.prog;

   sequence s_frame_start;
      slice_rise;
   endsequence

   sequence s_frame_clean;
      (q.taken == '0) && (q.frame_acc == '0);
   endsequence

   a_fwd_limit: assert property (@(posedge mclk) disable iff (rst)
      q.taken <= sem_pkg::TAKEN_W'(MAX_FWD))
      else $error("more events forwarded than allowed in one frame");
   a_accept_cap: assert property (@(posedge mclk) disable iff (rst)
      accept |=> (q.taken == $past(q.taken) + sem_pkg::TAKEN_W'(1)) && (q.taken <= sem_pkg::TAKEN_W'(MAX_FWD)))
      else $error("accepted event not counted");
   a_frame_clear: assert property (@(posedge mclk) disable iff (rst)
      s_frame_start |=> s_frame_clean)
      else $error("frame counts not cleared at slice boundary");
   a_ptr_rotate: assert property (@(posedge mclk) disable iff (rst)
      s_frame_start |=> (q.start_ptr == $past(q.start_ptr) + sem_pkg::PTR_W'(1)))
      else $error("priority start did not rotate");
   a_ctl_fanout: assert property (@(posedge mclk) disable iff (rst)
      ##1 (q.ctl[sem_pkg::CTL_W-1:0] == $past(ctl_from_main)) && (q.ctl == $past(ctl_fan)))
      else $error("control not fanned out to boards");
   a_reply_fanin: assert property (@(posedge mclk) disable iff (rst)
      ##1 reply_to_main == $past(|(reply_from_board & reply_mask)))
      else $error("board reply not gathered");
   a_peer_count: assert property (@(posedge mclk) disable iff (rst)
      s_frame_start |=> (peer_out == sem_pkg::PEER_W'($past(q.frame_acc))))
      else $error("peer count not published at frame start");
   a_clk_source: assert property (@(posedge mclk) disable iff (rst)
      $rose(coinc_present) ##1 coinc_present[*2] |-> ##1 clk_src_sel)
      else $error("clock source did not follow coincidence presence");
   a_link_word: assert property (@(posedge mclk) disable iff (rst)
      (buf_out_valid && buf_out_ready) |=> link_valid && (link_data == $past(buf_out_data)))
      else $error("word taken from buffer not shown on link");
   a_diag_insert: assert property (@(posedge mclk) disable iff (rst)
      (s_frame_start and diag_en) |=> q.diag_pend
         && (q.diag_word[sem_pkg::DIAG_TAG_LSB +: $bits(sem_pkg::DIAG_TAG)] == sem_pkg::DIAG_TAG))
      else $error("diagnostic word not queued");
endmodule : sem_mux

// ### tb/sem_main_model.sv
// Main controller model that clocks the event link and collects words.
`timescale 1ns/100ps
module sem_main_model (
   // Control from the bench
   input wire logic run,
   input wire logic stall,
   // Event link from the multiplexer
   input wire logic link_valid,
   input wire logic [sem_pkg::DW-1:0] link_data,
   output logic link_clk_in,
   output logic link_ready
);
   logic [sem_pkg::DW-1:0] words[$];

   // The offset keeps link edges clear of mclk edges, so sampling never races the design.
   initial
   begin
      link_clk_in = 1'b0;
      #1.3;
      forever
      begin
         #24;
         if (run)
         begin
            link_clk_in = ~link_clk_in;
            if (link_clk_in && link_valid === 1'b1)
               words.push_back(link_data);
         end
      end
   end

   assign link_ready = ~stall;
endmodule : sem_main_model

// ### tb/tb_top.sv
// Self-checking testbench of the singles event multiplexer.
`timescale 1ns/100ps
module tb_top;
   logic mclk, rst, slice_in, diag_en, coinc_present, run, stall;
   logic [15:0] ev_valid, peer_in, peer_out, link_data;
   logic [255:0] ev_data;
   logic [31:0] ctl_to_board, prog_to_board;
   logic [7:0] reply_from_board, reply_mask, user_to_main;
   logic [3:0] ctl_from_main, prog_from_main;
   logic link_clk_in, link_ready, link_valid, link_clk_out, slice_out, reply_to_main, clk_src_sel;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;

   sem_mux dut (.mclk(mclk), .rst(rst), .ev_valid(ev_valid), .ev_data(ev_data),
      .ctl_to_board(ctl_to_board), .prog_to_board(prog_to_board), .reply_from_board(reply_from_board),
      .reply_mask(reply_mask), .link_clk_in(link_clk_in), .slice_in(slice_in), .ctl_from_main(ctl_from_main),
      .prog_from_main(prog_from_main), .link_ready(link_ready), .link_valid(link_valid), .link_data(link_data),
      .link_clk_out(link_clk_out), .slice_out(slice_out), .user_to_main(user_to_main),
      .reply_to_main(reply_to_main), .peer_in(peer_in), .peer_out(peer_out), .diag_en(diag_en),
      .coinc_present(coinc_present), .clk_src_sel(clk_src_sel));
   sem_main_model main (.run(run), .stall(stall), .link_valid(link_valid), .link_data(link_data),
      .link_clk_in(link_clk_in), .link_ready(link_ready));

   initial
   begin
      mclk = 1'b0;
      forever
         #2.5 mclk = ~mclk;
   end

   task automatic give_verdict();
      if (failures == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict

   // A run far beyond the planned scenarios means a hang.
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         give_verdict();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick

   task automatic new_frame();
      int n;
      n = 0;
      @(posedge mclk);
      slice_in <= 1'b1;
      @(posedge mclk);
      #1;
      while (slice_out !== 1'b1 && n < 8)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      check("slice_out", {31'h0, slice_out}, 32'h1);
      @(posedge mclk);
      slice_in <= 1'b0;
      #1;
      check("slice_pulse", {31'h0, slice_out}, 32'h0);
      tick(4);
   endtask : new_frame

   task automatic t_frame_limit();
      int k;
      @(posedge mclk);
      stall <= 1'b1;
      main.words.delete();
      new_frame();
      for (k = 0; k < 16; k++)
      begin
         @(posedge mclk);
         ev_valid <= 16'h0001 << k;
         ev_data[k*16 +: 16] <= 16'h5A00 + 16'(k);
      end
      @(posedge mclk);
      ev_valid <= 16'h0000;
      tick(200);
      check("stalled_words", 32'(main.words.size()), 32'h0);
      check("fwd_state", {24'h0, user_to_main}, 32'h14);
      stall <= 1'b0;
      tick(600);
      check("fwd_count", 32'(main.words.size()), 32'h4);
      for (k = 0; k < 4; k++)
         check("fwd_word", {16'h0, main.words[k]}, {16'h0, 16'h5A00 + 16'(k)});
      new_frame();
      check("frame_count", {16'h0, peer_out}, 32'h10);
   endtask : t_frame_limit

   // All channels fire in one cycle; the winner must move on by one channel each frame.
   task automatic t_rotate();
      int k;
      logic [3:0] prev;
      prev = 4'h0;
      for (k = 0; k < 16; k++)
         ev_data[k*16 +: 16] <= 16'hC000 + 16'(k);
      for (k = 0; k < 3; k++)
      begin
         main.words.delete();
         new_frame();
         @(posedge mclk);
         ev_valid <= 16'hFFFF;
         @(posedge mclk);
         ev_valid <= 16'h0000;
         tick(100);
         check("one_per_cycle", 32'(main.words.size()), 32'h1);
         if (k > 0)
            check("rotation", {28'h0, main.words[0][3:0]}, {28'h0, prev + 4'h1});
         prev = main.words[0][3:0];
      end
   endtask : t_rotate

   task automatic t_diag();
      @(posedge mclk);
      peer_in <= 16'h0013;
      diag_en <= 1'b1;
      main.words.delete();
      tick(5);
      new_frame();
      check("peer_count", {16'h0, peer_out}, 32'h10);
      tick(100);
      check("diag_count", 32'(main.words.size()), 32'h1);
      check("diag_word", {16'h0, main.words[0]}, {16'h0, sem_pkg::DIAG_TAG, 2'b00, 5'h13, 5'h10});
      diag_en <= 1'b0;
   endtask : t_diag

   task automatic t_control();
      int b;
      @(posedge mclk);
      ctl_from_main <= 4'hA;
      prog_from_main <= 4'h5;
      @(posedge mclk);
      #1;
      check("ctl_fanout", ctl_to_board, {8{4'hA}});
      check("prog_fanout", prog_to_board, {8{4'h5}});
      for (b = 0; b < 8; b++)
      begin
         @(posedge mclk);
         reply_from_board <= 8'h01 << b;
         reply_mask <= 8'h01 << b;
         @(posedge mclk);
         reply_mask <= ~(8'h01 << b);
         #1;
         check("reply_on", {31'h0, reply_to_main}, 32'h1);
         @(posedge mclk);
         #1;
         check("reply_masked", {31'h0, reply_to_main}, 32'h0);
      end
   endtask : t_control

   task automatic t_clksel();
      int v;
      for (v = 1; v >= 0; v--)
      begin
         @(posedge mclk);
         coinc_present <= v[0];
         tick(4);
         #1;
         check("clk_src_sel", {31'h0, clk_src_sel}, 32'(v));
      end
      @(posedge link_clk_in);
      tick(4);
      #1;
      check("link_clk_high", {31'h0, link_clk_out}, 32'h1);
      @(negedge link_clk_in);
      tick(4);
      #1;
      check("link_clk_low", {31'h0, link_clk_out}, 32'h0);
   endtask : t_clksel

   initial
   begin
      rst = 1'b1;
      ev_valid = 16'h0000;
      ev_data = '0;
      reply_from_board = 8'h00;
      reply_mask = 8'h00;
      slice_in = 1'b0;
      ctl_from_main = 4'h0;
      prog_from_main = 4'h0;
      peer_in = 16'h0000;
      diag_en = 1'b0;
      coinc_present = 1'b0;
      run = 1'b0;
      stall = 1'b0;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      run <= 1'b1;
      tick(5);
      #1;
      check("idle_link", {31'h0, link_valid}, 32'h0);
      t_frame_limit();
      t_rotate();
      t_diag();
      t_control();
      t_clksel();
      give_verdict();
   end
endmodule : tb_top
